// ---- src/psfb_pkg.sv ----
// constants and carriers for the special flag bank
package psfb_pkg;
  // register indices (word addresses, 16-bit data)
  localparam logic [3:0] psfb_a_clock = 4'h0; // clock bits, read only
  localparam logic [3:0] psfb_a_ctrl = 4'h1; // ring enable, pulse controls
  localparam logic [3:0] psfb_a_err = 4'h2; // error flags
  localparam logic [3:0] psfb_a_code = 4'h3; // error code word
  localparam logic [3:0] psfb_a_ring = 4'h4; // ring counter value
  localparam logic [3:0] psfb_a_ien0 = 4'h5; // input and serial enables
  localparam logic [3:0] psfb_a_ien1 = 4'h6; // misc event enables
  localparam logic [3:0] psfb_a_cap = 4'h7; // capture latches
  // event enable word 1 bit positions
  localparam int psfb_e_pwr = 0;
  localparam int psfb_e_tmr = 1; // 3 bits
  localparam int psfb_e_hw_counter_instr = 4;
  localparam int psfb_e_hso = 5; // 8 bits
  localparam int psfb_ien1_w = 13;
  // ctrl word bit positions
  localparam int psfb_c_ring = 0;
  localparam int psfb_c_stop = 1; // 2 bits
  localparam int psfb_c_tbase = 3;
  localparam int psfb_c_clrf = 4;
  localparam int psfb_c_plsen = 5; // 4 bits
  localparam int psfb_c_envl = 9;
  localparam int psfb_c_grad = 10;
  localparam int psfb_ctrl_w = 11;
  // error flag bit positions
  localparam int psfb_f_exec = 0;
  localparam int psfb_f_subs = 1;
  localparam int psfb_f_parm = 2;
  localparam int psfb_f_done = 3;
  // clock word bit positions
  localparam int psfb_k_scan = 5;
  // timing, in nanoseconds at the 125 MHz ref clock
  localparam longint psfb_clk_ns = 8;
  localparam longint psfb_tick_ns = 100000; // 0.1 ms ring tick
  localparam int psfb_tick_cyc = int'(psfb_tick_ns / psfb_clk_ns);
  // half periods in 0.1 ms ticks: 10ms,100ms,1s,1min,1hour
  localparam logic [24:0] psfb_half_10ms = 25'h0000032;
  localparam logic [24:0] psfb_half_100ms = 25'h00001f4;
  localparam logic [24:0] psfb_half_1s = 25'h0001388;
  localparam logic [24:0] psfb_half_1min = 25'h00493e0;
  localparam logic [24:0] psfb_half_1hr = 25'h112a880;
  // instruction result report from the sequencer
  typedef struct packed {
    logic done; // one instruction finished
    logic fail; // it failed
    logic subs; // failure is subscript overflow
    logic parm; // failure is illegal parameter
    logic [15:0] code; // error type code
  } psfb_result_t;
  // interrupt sources, one bit per event
  typedef struct packed {
    logic [7:0] edge_ev; // input edges
    logic [11:0] ser_ev; // port*4 + {frx,ftx,crx,ctx}
    logic [psfb_ien1_w-1:0] misc_ev; // laid out like enable word 1
  } psfb_events_t;
endpackage : psfb_pkg

// ---- src/psfb_bank.sv ----
// special flag bank: clock bits, error flags, enables, capture latches
`timescale 1ns/1ps
module psfb_bank #(
  parameter int tick_cyc = psfb_pkg::psfb_tick_cyc // cycles per 0.1 ms
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic run_mode, // controller in run state (pin)
  input wire logic scan_end, // one pulse per program scan
  input wire psfb_pkg::psfb_result_t instr_res,
  input wire logic serial_rw_done, // serial read/write instr finished
  input wire logic [7:0] input_pin, // raw digital inputs
  input wire logic [7:0] hw_count_busy, // counter/speed instr on input
  input wire logic [1:0] pulse_busy, // pulse generators busy
  input wire logic origin_return_busy, // origin return in progress
  input wire psfb_pkg::psfb_events_t events, // interrupt sources
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [1:0] pulse_stop, // stop commands to generators
  output logic pwm_timebase_select, // 1 microseconds, 0 milliseconds
  output logic position_clear_signal,
  output logic [3:0] pulse_train_en,
  output logic envelope_loop,
  output logic gradual_freq,
  output logic irq_req // one-cycle forwarded interrupt
);
  // refuse a divider too short to give a one-cycle tick
  if (tick_cyc < 2) begin : g_bad_tick
    $error("tick_cyc too small");
  end

  // register map, 16-bit words
  //   word 0: clock bits, scan toggle in bit 5, read only
  //   word 1: control; pulse busy monitor in bits 12:11, read only
  //   word 2: error flags {done, parm, subs, exec}, read only
  //   word 3: error code word; a write here sets port 2 serial enables
  //   word 4: ring counter value, read only
  //   word 5: input edge enables and serial ports 0 and 1 enables
  //   word 6: power, timer, counter and output-complete enables
  //   word 7: capture latches, port 2 enables read back in bits 11:8
  //   unmapped words read as zero and ignore writes
  // behaviour on run start
  //   every bank bit clears on the stop-to-run edge, as after reset
  //   the tick divider restarts too, so clock bit phase is exact
  //   clock bits are held low while stopped, so each run starts low
  // timing
  //   run_mode and input_pin cross two flops before any logic
  //   so the stop-to-run edge is seen three edges after the pin rises
  //   control outputs follow a write by two edges (word, then output)
  //   read data stand only in the cycle after the read strobe
  // limitations
  //   the one minute and one hour bits need long runs to observe
  //   the subscript flag is not cleared by a later success
  //   the completion flag stays set until the next run start

  // one write strobe per word address
  function automatic logic wr_hit(input logic wr, input logic [3:0] addr,
    input logic [3:0] word);
    return wr && (addr == word);
  endfunction : wr_hit

  // synchronised pins
  logic [8:0] sync1_ff, sync2_ff; // {run, inputs}
  logic [7:0] in_prev_ff;
  logic run_prev_ff;
  wire [7:0] in_s = sync2_ff[7:0];
  wire run_s = sync2_ff[8];
  wire start_pulse = run_s & ~run_prev_ff; // stop-to-run transition
  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {run_mode, input_pin};
      sync2_ff <= sync1_ff;
    end
  end
  // edge history
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      in_prev_ff <= '0;
      run_prev_ff <= 1'b0;
    end else begin
      in_prev_ff <= in_s;
      run_prev_ff <= run_s;
    end
  end

  // 0.1 ms tick divider, restarted at run start so phase is clean
  logic [31:0] div_ff;
  wire tick = (div_ff == 32'(tick_cyc - 1));
  always_ff @(posedge ref_clk) begin
    if (!reset_n || start_pulse) div_ff <= '0;
    else if (tick) div_ff <= '0;
    else div_ff <= div_ff + 32'h1;
  end

  // five clock bits; counters held in stop so each starts at run
  localparam logic [24:0] half_tab [5] = '{psfb_pkg::psfb_half_10ms,
    psfb_pkg::psfb_half_100ms, psfb_pkg::psfb_half_1s,
    psfb_pkg::psfb_half_1min, psfb_pkg::psfb_half_1hr};
  // each stage owns its own flop, so no bit has two writers
  wire [4:0] clk_bits; // collected clock bits for the read mux
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_clk
      logic [24:0] cnt_ff; // ticks within the half period
      logic bit_ff; // this stage's square wave
      wire wrap = (cnt_ff == half_tab[g] - 25'h1);
      // bit low for first half period after run begins
      always_ff @(posedge ref_clk) begin
        if (!reset_n || start_pulse || !run_s) begin
          cnt_ff <= '0;
          bit_ff <= 1'b0;
        end else if (tick) begin
          cnt_ff <= wrap ? 25'h0 : cnt_ff + 25'h1;
          if (wrap) bit_ff <= ~bit_ff;
        end
      end
      assign clk_bits[g] = bit_ff;
    end
  endgenerate

  // scan toggle, low during first scan
  logic scan_toggle_bit_ff;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || start_pulse) scan_toggle_bit_ff <= 1'b0;
    else if (scan_end && run_s) scan_toggle_bit_ff <= ~scan_toggle_bit_ff;
  end

  // write decode
  wire wr_ctrl = wr_hit(reg_wr, reg_addr, psfb_pkg::psfb_a_ctrl);
  wire wr_ien0 = wr_hit(reg_wr, reg_addr, psfb_pkg::psfb_a_ien0);
  wire wr_ien1 = wr_hit(reg_wr, reg_addr, psfb_pkg::psfb_a_ien1);
  wire wr_cap = wr_hit(reg_wr, reg_addr, psfb_pkg::psfb_a_cap);

  // control word; cleared on stop-to-run like all bank bits
  logic [psfb_pkg::psfb_ctrl_w-1:0] ctrl_ff;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || start_pulse) ctrl_ff <= '0;
    else if (wr_ctrl) ctrl_ff <= reg_wdata[psfb_pkg::psfb_ctrl_w-1:0];
  end
  wire ring_counter_enable = ctrl_ff[psfb_pkg::psfb_c_ring];

  // output controls
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pulse_stop <= '0;
      pwm_timebase_select <= 1'b0;
      position_clear_signal <= 1'b0;
      pulse_train_en <= '0;
      envelope_loop <= 1'b0;
      gradual_freq <= 1'b0;
    end else begin
      pulse_stop <= ctrl_ff[psfb_pkg::psfb_c_stop +: 2];
      pwm_timebase_select <= ctrl_ff[psfb_pkg::psfb_c_tbase];
      position_clear_signal <= ctrl_ff[psfb_pkg::psfb_c_clrf]
        & origin_return_busy;
      pulse_train_en <= ctrl_ff[psfb_pkg::psfb_c_plsen +: 4];
      envelope_loop <= ctrl_ff[psfb_pkg::psfb_c_envl];
      gradual_freq <= ctrl_ff[psfb_pkg::psfb_c_grad];
    end
  end

  // ring counter, counting ticks while enabled and wrapping at 16 bits
  logic [15:0] ring_ff;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || start_pulse) ring_ff <= '0;
    else if (ring_counter_enable && tick) ring_ff <= ring_ff + 16'h1;
  end

  // error flags; a failure in the same report beats the success clear
  logic exec_error_flag_ff, subs_ff, parm_ff, done_ff;
  logic [15:0] error_code_word_ff;
  wire ok = instr_res.done && !instr_res.fail;
  wire bad = instr_res.done && instr_res.fail;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || start_pulse) begin
      exec_error_flag_ff <= 1'b0;
      subs_ff <= 1'b0;
      parm_ff <= 1'b0;
      error_code_word_ff <= '0;
    end else if (bad) begin
      exec_error_flag_ff <= 1'b1;
      error_code_word_ff <= instr_res.code;
      if (instr_res.subs) subs_ff <= 1'b1;
      if (instr_res.parm) parm_ff <= 1'b1;
    end else if (ok) begin
      exec_error_flag_ff <= 1'b0;
      parm_ff <= 1'b0;
      // subscript flag stays until the next run start
    end
  end
  // completion flag sticky until run start
  always_ff @(posedge ref_clk) begin
    if (!reset_n || start_pulse) done_ff <= 1'b0;
    else if (serial_rw_done) done_ff <= 1'b1;
  end

  // interrupt enables
  logic [15:0] ien0_ff; // [7:0] inputs, [15:8] serial ports 0 and 1
  logic [psfb_pkg::psfb_ien1_w-1:0] ien1_ff;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || start_pulse) begin
      ien0_ff <= '0;
      ien1_ff <= '0;
    end else begin
      if (wr_ien0) ien0_ff <= reg_wdata;
      if (wr_ien1) ien1_ff <= reg_wdata[psfb_pkg::psfb_ien1_w-1:0];
    end
  end
  // port 2 serial enables: written through the code word address,
  // read back beside the capture latches; the code word stays read only
  logic [3:0] ser2_en_ff;
  wire wr_ser2 = wr_hit(reg_wr, reg_addr, psfb_pkg::psfb_a_code);
  always_ff @(posedge ref_clk) begin
    if (!reset_n || start_pulse) ser2_en_ff <= '0;
    else if (wr_ser2) ser2_en_ff <= reg_wdata[3:0];
  end
  wire [11:0] ser_en = {ser2_en_ff, ien0_ff[15:8]};

  // edge events from pins combine with other sources
  wire [7:0] pin_edge = in_s ^ in_prev_ff;
  wire any_ev = |((pin_edge | events.edge_ev) & ien0_ff[7:0])
    | |(events.ser_ev & ser_en) | |(events.misc_ev & ien1_ff);
  always_ff @(posedge ref_clk) begin
    if (!reset_n) irq_req <= 1'b0;
    else irq_req <= run_s & any_ev;
  end

  // capture latches; hardware set wins over software write
  logic [7:0] cap_ff;
  wire [7:0] cap_set = in_s & ~in_prev_ff & ~hw_count_busy;
  always_ff @(posedge ref_clk) begin
    if (!reset_n || start_pulse) cap_ff <= '0;
    else if (wr_cap) cap_ff <= reg_wdata[7:0] | cap_set;
    else cap_ff <= cap_ff | cap_set;
  end

  // read mux, registered so data stand one cycle after the strobe
  logic [15:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      psfb_pkg::psfb_a_clock: rd_mux = {10'h0, scan_toggle_bit_ff, clk_bits};
      psfb_pkg::psfb_a_ctrl: rd_mux = {3'h0, pulse_busy, ctrl_ff};
      psfb_pkg::psfb_a_err: rd_mux = {12'h0, done_ff, parm_ff, subs_ff,
        exec_error_flag_ff};
      psfb_pkg::psfb_a_code: rd_mux = error_code_word_ff;
      psfb_pkg::psfb_a_ring: rd_mux = ring_ff;
      psfb_pkg::psfb_a_ien0: rd_mux = ien0_ff[15:0];
      psfb_pkg::psfb_a_ien1: rd_mux = {3'h0, ien1_ff};
      psfb_pkg::psfb_a_cap: rd_mux = {4'h0, ser2_en_ff, cap_ff};
      default: rd_mux = 16'h0;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) reg_rdata <= '0;
    else reg_rdata <= reg_rd ? rd_mux : 16'h0;
  end
endmodule : psfb_bank

// ---- sim/psfb_bank_sva.sv ----
// port assertions for the special flag bank
`timescale 1ns/1ps
module psfb_bank_sva (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic run_mode,
  input wire logic [1:0] pulse_busy,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [1:0] pulse_stop,
  input wire logic pwm_timebase_select,
  input wire logic [3:0] pulse_train_en,
  input wire logic envelope_loop,
  input wire logic gradual_freq,
  input wire logic irq_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // control word write; word lands at the write edge, outputs one edge later
  wire wc = reg_wr && reg_addr == psfb_pkg::psfb_a_ctrl;
  // control word read, busy bits captured at the read edge
  wire rc = reg_rd && reg_addr == psfb_pkg::psfb_a_ctrl;
  // clock word read
  wire rk = reg_rd && reg_addr == psfb_pkg::psfb_a_clock;
  property p_stop; wc |-> ##2 pulse_stop == $past(reg_wdata[2:1], 2); endproperty
  a_stop: assert property (p_stop) else $error("stop bits wrong");
  property p_tbase; wc |-> ##2 pwm_timebase_select == $past(reg_wdata[3], 2); endproperty
  a_tbase: assert property (p_tbase) else $error("timebase wrong");
  property p_plsen; wc |-> ##2 pulse_train_en == $past(reg_wdata[8:5], 2); endproperty
  a_plsen: assert property (p_plsen) else $error("pulse enables wrong");
  property p_envl; wc |-> ##2 envelope_loop == $past(reg_wdata[9], 2); endproperty
  a_envl: assert property (p_envl) else $error("envelope loop wrong");
  property p_grad; wc |-> ##2 gradual_freq == $past(reg_wdata[10], 2); endproperty
  a_grad: assert property (p_grad) else $error("gradual bit wrong");
  property p_busy; rc |=> reg_rdata[12:11] == $past(pulse_busy); endproperty
  a_busy: assert property (p_busy) else $error("busy readback wrong");
  // clock bits stay low while the controller is stopped
  property p_clk; !run_mode [*5] ##0 rk |=> reg_rdata[4:0] == 5'h00; endproperty
  a_clk: assert property (p_clk) else $error("clock bits not low");
  property p_irq; !run_mode [*5] |=> !irq_req; endproperty
  a_irq: assert property (p_irq) else $error("request while stopped");
endmodule : psfb_bank_sva
bind psfb_bank psfb_bank_sva i_psfb_bank_sva (.ref_clk, .reset_n, .run_mode, .pulse_busy,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pulse_stop, .pwm_timebase_select,
  .pulse_train_en, .envelope_loop, .gradual_freq, .irq_req);

// ---- sim/psfb_bank_test.sv ----
// self-checking bench for the special flag bank
`timescale 1ns/1ps
module psfb_bank_test;
  localparam int tc = 10; // short tick keeps the clock bits up to 1 s reachable
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic run_mode = 1'b0;
  logic scan_end = 1'b0;
  psfb_pkg::psfb_result_t instr_res = '0;
  logic serial_rw_done = 1'b0;
  logic [7:0] input_pin = 8'h00;
  logic [7:0] hw_count_busy = 8'h00;
  logic [1:0] pulse_busy = 2'h0;
  logic origin_return_busy = 1'b0;
  psfb_pkg::psfb_events_t events = '0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [1:0] pulse_stop;
  logic [3:0] pulse_train_en;
  logic pwm_timebase_select, position_clear_signal, envelope_loop, gradual_freq, irq_req;
  int fails = 0;
  int tests_run = 0;
  int n;
  logic [31:0] seed = 32'h00000005; // fixed seed, repeatable run
  logic [15:0] d, r0, r1;
  logic [3:0] r2;
  logic [1:0] pb;
  time ts; // moment the run state was requested
  psfb_bank #(.tick_cyc(tc)) i_psfb_bank (.ref_clk, .reset_n, .run_mode, .scan_end,
    .instr_res, .serial_rw_done, .input_pin, .hw_count_busy, .pulse_busy,
    .origin_return_busy, .events, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pulse_stop, .pwm_timebase_select, .position_clear_signal, .pulse_train_en,
    .envelope_loop, .gradual_freq, .irq_req);
  initial forever #4 ref_clk = ~ref_clk;
  // xorshift step
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // enable bit that governs packed event bit b
  function automatic logic ie(input int b);
    if (b < 13) return r1[b];
    if (b < 21) return r0[b - 5];
    if (b < 25) return r2[b - 21];
    return r0[b - 25];
  endfunction : ie
  task automatic end_of_test();
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge ref_clk) reg_wr <= 1'b0;
    #1;
  endtask : wr
  // data stand in the cycle after the read edge only
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1;
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    rd(a);
    chk(reg_rdata & m, e);
  endtask : rdc
  task automatic res(input logic [2:0] fsp, input logic [15:0] c);
    @(posedge ref_clk) instr_res <= {1'b1, fsp, c};
    @(posedge ref_clk) instr_res <= '0;
  endtask : res
  // poll a clock bit, then compare elapsed cycles since run start
  task automatic waitb(input int k, input logic v, input int ec);
    int dt;
    for (int i = 0; i < 30000; i++) begin
      rd(psfb_pkg::psfb_a_clock);
      if (reg_rdata[k] === v) break;
    end
    dt = int'(($time - ts) / 8);
    chk(dt > ec - 12 && dt < ec + 12, 1);
  endtask : waitb
  initial begin
    repeat (99000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    // reset values, read-only words and one unmapped word
    for (int a = 0; a < 9; a++) begin
      if (a == 0 || a == 2 || a == 4) wr(4'(a), 16'(rnd()));
      rdc(4'(a), 16'h0000, 16'hffff);
    end
    repeat (8) begin
      d = 16'(rnd()) & 16'h07ff;
      pb = 2'(rnd());
      pulse_busy <= pb;
      wr(psfb_pkg::psfb_a_ctrl, d);
      // outputs are one flop behind the control word
      @(posedge ref_clk);
      #1;
      chk({gradual_freq, envelope_loop, pulse_train_en, pwm_timebase_select, pulse_stop},
        {d[10:5], d[3:1]});
      chk(position_clear_signal, 0);
      rdc(psfb_pkg::psfb_a_ctrl, {pb, d[10:0]}, 16'h1fff);
    end
    // clear output follows origin return only when enabled
    for (int c = 1; c >= 0; c--) begin
      wr(psfb_pkg::psfb_a_ctrl, c ? 16'h0010 : 16'h0000);
      origin_return_busy <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 chk(position_clear_signal, c);
      origin_return_busy <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 chk(position_clear_signal, 0);
    end
    @(posedge ref_clk) run_mode <= 1'b1;
    ts = $time;
    repeat (6) @(posedge ref_clk);
    rdc(psfb_pkg::psfb_a_clock, 16'h0000, 16'h003f);
    for (int i = 1; i < 5; i++) begin
      @(posedge ref_clk) scan_end <= 1'b1;
      @(posedge ref_clk) scan_end <= 1'b0;
      rdc(psfb_pkg::psfb_a_clock, 16'(i % 2) << 5, 16'h0020);
    end
    // ring counter runs about 102 cycles, then must freeze
    wr(psfb_pkg::psfb_a_ctrl, 16'h0001);
    repeat (100) @(posedge ref_clk);
    wr(psfb_pkg::psfb_a_ctrl, 16'h0000);
    rd(psfb_pkg::psfb_a_ring);
    d = reg_rdata;
    chk(d > 16'h0008 && d < 16'h000d, 1);
    repeat (50) @(posedge ref_clk);
    rdc(psfb_pkg::psfb_a_ring, d, 16'hffff);
    d = 16'(rnd());
    res(3'b101, d);
    rdc(psfb_pkg::psfb_a_err, 16'h0005, 16'h0007);
    rdc(psfb_pkg::psfb_a_code, d, 16'hffff);
    res(3'b000, 16'h0000);
    rdc(psfb_pkg::psfb_a_err, 16'h0000, 16'h0007);
    res(3'b110, d ^ 16'h00ff);
    rdc(psfb_pkg::psfb_a_code, d ^ 16'h00ff, 16'hffff);
    res(3'b000, 16'h0000);
    rdc(psfb_pkg::psfb_a_err, 16'h0002, 16'h0007);
    @(posedge ref_clk) serial_rw_done <= 1'b1;
    @(posedge ref_clk) serial_rw_done <= 1'b0;
    rdc(psfb_pkg::psfb_a_err, 16'h0008, 16'h0008);
    waitb(0, 1'b1, int'(psfb_pkg::psfb_half_10ms) * tc);
    waitb(0, 1'b0, 2 * int'(psfb_pkg::psfb_half_10ms) * tc);
    waitb(1, 1'b1, int'(psfb_pkg::psfb_half_100ms) * tc);
    waitb(2, 1'b1, int'(psfb_pkg::psfb_half_1s) * tc);
    // capture on pin 3; pin 5 is owned by a counter
    hw_count_busy <= 8'h20;
    input_pin <= 8'h28;
    repeat (5) @(posedge ref_clk);
    rdc(psfb_pkg::psfb_a_cap, 16'h0008, 16'h00ff);
    wr(psfb_pkg::psfb_a_cap, 16'h0000);
    rdc(psfb_pkg::psfb_a_cap, 16'h0000, 16'h00ff);
    hw_count_busy <= 8'h00;
    input_pin <= 8'h29;
    repeat (5) @(posedge ref_clk);
    rdc(psfb_pkg::psfb_a_cap, 16'h0001, 16'h00ff);
    run_mode <= 1'b0;
    repeat (6) @(posedge ref_clk);
    run_mode <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdc(psfb_pkg::psfb_a_cap, 16'h0000, 16'h00ff);
    r0 = 16'(rnd());
    r1 = 16'(rnd()) & 16'h1fff;
    r2 = 4'(rnd());
    wr(psfb_pkg::psfb_a_ien0, r0);
    wr(psfb_pkg::psfb_a_ien1, r1);
    wr(psfb_pkg::psfb_a_code, {12'h000, r2});
    rdc(psfb_pkg::psfb_a_ien0, r0, 16'hffff);
    rdc(psfb_pkg::psfb_a_ien1, r1, 16'h1fff);
    rdc(psfb_pkg::psfb_a_cap, {4'h0, r2, 8'h00}, 16'h0f00);
    // every event source alone, forwarded only where enabled
    for (int b = 0; b < 33; b++) begin
      events <= 33'h1 << b;
      @(posedge ref_clk) events <= '0;
      n = 0;
      repeat (4) begin
        #1 if (irq_req === 1'b1) n++;
        @(posedge ref_clk);
      end
      chk(n, ie(b));
      #1;
    end
    // pin 1 enabled: rise and fall each forward once; pin 2 disabled
    wr(psfb_pkg::psfb_a_ien0, 16'h0002);
    for (int v = 0; v < 3; v++) begin
      input_pin <= input_pin ^ (v < 2 ? 8'h02 : 8'h04);
      n = 0;
      repeat (8) begin
        @(posedge ref_clk);
        #1 if (irq_req === 1'b1) n++;
      end
      chk(n, v < 2);
    end
    end_of_test();
  end
endmodule : psfb_bank_test
